/* pkg/tpwm_consts.svh */
// Register offsets, field positions and reset values of the two-channel modulator.
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH
`define TPWM_ADDR_DUTY0     8'ha1
`define TPWM_ADDR_DUTY1     8'ha2
`define TPWM_ADDR_CONTROL   8'hb2
`define TPWM_RESET_VALUE    8'h00
`define TPWM_RES_MSB        7
`define TPWM_RES_LSB        6
`define TPWM_PRE_MSB        5
`define TPWM_PRE_LSB        2
`define TPWM_EN1_BIT        1
`define TPWM_EN0_BIT        0
`endif

/* pkg/tpwm_pkg.sv */
// Types shared by the two-channel modulator.
`default_nettype none
package tpwm_pkg;
  typedef enum logic [1:0] {
    TPWM_RES5 = 2'h0,
    TPWM_RES6 = 2'h1,
    TPWM_RES7 = 2'h2,
    TPWM_RES8 = 2'h3
  } tpwm_res_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpwm_sfr_s;
endpackage

`default_nettype wire

/* verilog/tpwm_top.sv */
// Two-channel pulse-width modulator on the special-function-register space.
// What this block does
// - Two channels share one resolution and prescaler; each has its own duty register.
// - Control bits 7:6 choose a 5, 6, 7 or 8 bit counter.
// - Control bits 5:2 divide the core clock by field plus one.
// - One period lasts (2^n - 1) times (prescale + 1) clock cycles.
// - High fraction is the low n duty bits over 2^n - 1.
// - A duty write changes the output at once, not at period end.
// - A mid-period rewrite keeps the average between old and new duty.
// - Control bit 1 enables channel 1 onto its pin.
// - Control bit 0 enables channel 0 onto its pin.
// - Duty registers are 8 bits; only the low n bits act.
`timescale 1ns/1ns
`default_nettype none
`include "tpwm_consts.svh"

module tpwm_top (
  // Clock, reset and freeze
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // Register access from the core
  input  wire tpwm_pkg::tpwm_sfr_s sfr,
  output logic [7:0]             sfr_rdata,
  output logic                   sfr_hit,
  // Port pins
  output logic                   channel0_output,
  output logic                   channel1_output
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] modulator_control;
  logic [7:0] duty_cycle_channel0;
  logic [7:0] duty_cycle_channel1;
  logic [3:0] prescale_count;
  logic [7:0] period_count;
  logic       tick;
  logic [7:0] top_value;
  logic [7:0] next_rdata;

  // Mask of the bits that take effect at a given resolution.
  function automatic logic [7:0] res_mask(input logic [1:0] res);
    unique case (tpwm_pkg::tpwm_res_e'(res))
      tpwm_pkg::TPWM_RES5: res_mask = 8'h1f;
      tpwm_pkg::TPWM_RES6: res_mask = 8'h3f;
      tpwm_pkg::TPWM_RES7: res_mask = 8'h7f;
      tpwm_pkg::TPWM_RES8: res_mask = 8'hff;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modulator_control   <= `TPWM_RESET_VALUE;
      duty_cycle_channel0 <= `TPWM_RESET_VALUE;
      duty_cycle_channel1 <= `TPWM_RESET_VALUE;
    end else if (ce && sfr.wr) begin
      // Duty writes land straight in the compare path, so the output follows at once.
      if (sfr.addr == `TPWM_ADDR_CONTROL) modulator_control <= sfr.wdata;
      if (sfr.addr == `TPWM_ADDR_DUTY0) duty_cycle_channel0 <= sfr.wdata;
      if (sfr.addr == `TPWM_ADDR_DUTY1) duty_cycle_channel1 <= sfr.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data holds until the next read, so a slow core may collect it late.
  always_comb begin
    next_rdata = 8'h00;
    sfr_hit    = 1'b1;
    unique case (sfr.addr)
      `TPWM_ADDR_CONTROL: next_rdata = modulator_control;
      `TPWM_ADDR_DUTY0:   next_rdata = duty_cycle_channel0;
      `TPWM_ADDR_DUTY1:   next_rdata = duty_cycle_channel1;
      default:            sfr_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr.rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and period counter
  // ----------------------------------------------------------------
  assign top_value = res_mask(modulator_control[`TPWM_RES_MSB:`TPWM_RES_LSB]);
  // Ticking on reaching or passing the factor means a lowered factor costs one short step,
  // not a run through all sixteen prescaler states.
  assign tick = (prescale_count >= modulator_control[`TPWM_PRE_MSB:`TPWM_PRE_LSB]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_count <= 4'h0;
    end else if (ce) begin
      prescale_count <= tick ? 4'h0 : prescale_count + 4'h1;
    end
  end

  // Counter runs 0 .. top-1, so a period is 2^n - 1 ticks; duty of all ones stays high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_count <= 8'h00;
    end else if (ce && tick) begin
      if (period_count >= top_value - 8'h01) period_count <= 8'h00;
      else period_count <= period_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered compare; a rewrite only moves the edge, so the average stays between values.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel0_output <= 1'b0;
      channel1_output <= 1'b0;
    end else if (ce) begin
      channel0_output <= modulator_control[`TPWM_EN0_BIT] &&
        (period_count < (duty_cycle_channel0 & top_value));
      channel1_output <= modulator_control[`TPWM_EN1_BIT] &&
        (period_count < (duty_cycle_channel1 & top_value));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A control write may move the top or the factor under a running count, so the
  // bound checks leave out the step that follows one.
  logic ctl_wr;

  assign ctl_wr = ce && sfr.wr && (sfr.addr == `TPWM_ADDR_CONTROL);

  sequence ctl_write_s;
    ce && sfr.wr && sfr.addr == `TPWM_ADDR_CONTROL;
  endsequence

  sequence duty0_write_s;
    ce && sfr.wr && sfr.addr == `TPWM_ADDR_DUTY0;
  endsequence

  sequence duty1_write_s;
    ce && sfr.wr && sfr.addr == `TPWM_ADDR_DUTY1;
  endsequence

  // Every state element here is a flop, so each property but the two resolution checks looks one edge behind the logic.
  ctl_write_a: assert property (@(posedge clk) disable iff (!rstn)
    ctl_write_s |=> modulator_control == $past(sfr.wdata))
    else $error("control write not taken");

  duty0_write_a: assert property (@(posedge clk) disable iff (!rstn)
    duty0_write_s |=> duty_cycle_channel0 == $past(sfr.wdata))
    else $error("duty 0 write not taken");

  duty_write_a: assert property (@(posedge clk) disable iff (!rstn)
    duty1_write_s |=> duty_cycle_channel1 == $past(sfr.wdata))
    else $error("duty write not taken");

  counter_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && !ctl_wr |=> period_count < top_value)
    else $error("period counter passed its top");

  wrap_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && period_count == top_value - 8'h01 |=> period_count == 8'h00)
    else $error("counter did not wrap");

  count_step_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && period_count < top_value - 8'h01 && !sfr.wr |=>
      period_count == $past(period_count) + 8'h01)
    else $error("counter did not step");

  prescale_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !ctl_wr |=> prescale_count <= modulator_control[`TPWM_PRE_MSB:`TPWM_PRE_LSB])
    else $error("prescaler passed its factor");

  res_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    modulator_control[7:6] == 2'h0 |-> top_value == 8'h1f)
    else $error("5 bit resolution wrong");

  res8_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    modulator_control[7:6] == 2'h3 |-> top_value == 8'hff)
    else $error("8 bit resolution wrong");

  ch0_disable_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !modulator_control[`TPWM_EN0_BIT] |=> !channel0_output)
    else $error("channel 0 high while disabled");

  ch1_disable_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !modulator_control[`TPWM_EN1_BIT] |=> !channel1_output)
    else $error("channel 1 high while disabled");

  ch0_compare_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> channel0_output == ($past(modulator_control[0]) &&
      $past(period_count) < ($past(duty_cycle_channel0) & $past(top_value))))
    else $error("channel 0 compare wrong");

  ch1_compare_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> channel1_output == ($past(modulator_control[`TPWM_EN1_BIT]) &&
      $past(period_count) < ($past(duty_cycle_channel1) & $past(top_value))))
    else $error("channel 1 compare wrong");

  full_duty_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && modulator_control[`TPWM_EN0_BIT] &&
      (duty_cycle_channel0 & top_value) == top_value |=> channel0_output)
    else $error("full duty not held high");

  zero_duty_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && (duty_cycle_channel0 & top_value) == 8'h00 |=> !channel0_output)
    else $error("zero duty not held low");

  read_back_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && sfr.rd && sfr.addr == `TPWM_ADDR_DUTY0 |=>
      sfr_rdata == $past(duty_cycle_channel0))
    else $error("duty 0 read back wrong");

  state_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(period_count) && $stable(prescale_count))
    else $error("state moved while frozen");

  reg_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(modulator_control) && $stable(duty_cycle_channel1) &&
      $stable(channel0_output) && $stable(channel1_output))
    else $error("registers moved while frozen");
endmodule

`default_nettype wire

/* tb/tpwm_load.sv */
// Load model on the two port pins that tallies high cycles.
`timescale 1ns/1ns
`default_nettype none
module tpwm_load (
  // Clock and tally clear
  input  wire logic   clk,
  input  wire logic   clr,
  // Port pins
  input  wire logic   pin0,
  input  wire logic   pin1,
  // Tallies
  output logic [15:0] hi0,
  output logic [15:0] hi1
);
  // A tally over a whole period does not depend on the phase of the wave.
  always_ff @(posedge clk) begin
    if (clr) begin
      hi0 <= 16'h0000;
      hi1 <= 16'h0000;
    end else begin
      hi0 <= hi0 + {15'h0000, pin0};
      hi1 <= hi1 + {15'h0000, pin1};
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the two-channel modulator.
`timescale 1ns/1ns
`default_nettype none
`include "tpwm_consts.svh"
module tb;
  logic                clk;
  logic                rstn;
  logic                ce;
  logic                clr;
  tpwm_pkg::tpwm_sfr_s sfr;
  logic [7:0]          rdat;
  logic                hit;
  logic                ch0;
  logic                ch1;
  logic [15:0]         hi0;
  logic [15:0]         hi1;
  logic [15:0]         top;
  logic [7:0]          ctrl;
  int                  error_cnt;
  int                  num_checks;
  tpwm_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .sfr(sfr), .sfr_rdata(rdat),
    .sfr_hit(hit), .channel0_output(ch0), .channel1_output(ch1));
  tpwm_load u_load (.clk(clk), .clr(clr), .pin0(ch0), .pin1(ch1), .hi0(hi0), .hi1(hi1));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    #1 chk(16'(hit), 16'(h));
    @(posedge clk);
    sfr.rd <= 1'b0;
    @(posedge clk);
    #1 chk(16'(rdat), 16'(exp));
  endtask
  task automatic clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    clr = 1'b0;
    sfr = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(`TPWM_ADDR_DUTY0, `TPWM_RESET_VALUE, 1'b1);
    rd(`TPWM_ADDR_DUTY1, `TPWM_RESET_VALUE, 1'b1);
    rd(`TPWM_ADDR_CONTROL, `TPWM_RESET_VALUE, 1'b1);
    wr(8'h55, 8'h77);
    rd(8'h55, 8'h00, 1'b0);
    rd(`TPWM_ADDR_CONTROL, `TPWM_RESET_VALUE, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      ctrl = {i[1:0], i[3:0], ~i[1:0]};
      top = (16'h0001 << (i + 5)) - 16'h0001;
      wr(`TPWM_ADDR_CONTROL, ctrl);
      wr(`TPWM_ADDR_DUTY0, 8'hf3);
      wr(`TPWM_ADDR_DUTY1, 8'h0a);
      rd(`TPWM_ADDR_CONTROL, ctrl, 1'b1);
      repeat (2 * top * (i + 1) + 40) @(posedge clk);
      clear();
      repeat (top * (i + 1)) @(posedge clk);
      #1 chk(hi0, ctrl[0] ? 16'((top & 16'h00f3) * (i + 1)) : 16'h0000);
      chk(hi1, ctrl[1] ? 16'(10 * (i + 1)) : 16'h0000);
      $display("test mode %0d done", i);
    end
    wr(`TPWM_ADDR_CONTROL, 8'h01);
    wr(`TPWM_ADDR_DUTY0, 8'h00);
    repeat (40) @(posedge clk);
    #1 chk(16'(ch0), 16'h0000);
    wr(`TPWM_ADDR_DUTY0, 8'h1f);
    repeat (2) @(posedge clk);
    #1 chk(16'(ch0), 16'h0001);
    wr(`TPWM_ADDR_DUTY0, 8'h04);
    repeat (40) @(posedge clk);
    clear();
    repeat (10) @(posedge clk);
    wr(`TPWM_ADDR_DUTY0, 8'h14);
    repeat (19) @(posedge clk);
    #1 chk(16'(hi0 >= 16'h0004 && hi0 <= 16'h0014), 16'h0001);
    @(posedge clk);
    ce <= 1'b0;
    wr(`TPWM_ADDR_DUTY1, 8'h55);
    ce <= 1'b1;
    rd(`TPWM_ADDR_DUTY1, 8'h0a, 1'b1);
    $display("test update done");
    stop_test();
  end
endmodule
`default_nettype wire
